// ---- common/psirq_pkg.sv ----
/*
  Shared constants for the power state and interrupt routing block:
  register offsets, field positions, reset values, state codes, timing.
  Assumes a 100 MHz core clock and an 8-bit register port.
*/
`default_nettype none

package psirq_pkg;

  // Operating states, codes as written into the mode register
  typedef enum logic [1:0] {
    ST_SLEEP   = 2'b00,
    ST_WAKE    = 2'b01,
    ST_STANDBY = 2'b11
  } psirq_state_e;

  localparam logic [1:0] MODE_CODE_SLEEP   = 2'h0;
  localparam logic [1:0] MODE_CODE_WAKE    = 2'h1;
  localparam logic [1:0] MODE_CODE_STANDBY = 2'h3;

  // Register offsets
  localparam logic [7:0] REG_STATUS     = 8'h05;
  localparam logic [7:0] REG_IRQ_EN     = 8'h06;
  localparam logic [7:0] REG_MODE       = 8'h07;
  localparam logic [7:0] REG_RATE       = 8'h08;
  localparam logic [7:0] REG_X_LO       = 8'h0D;
  localparam logic [7:0] REG_X_HI       = 8'h0E;
  localparam logic [7:0] REG_Y_LO       = 8'h0F;
  localparam logic [7:0] REG_Y_HI       = 8'h10;
  localparam logic [7:0] REG_Z_LO       = 8'h11;
  localparam logic [7:0] REG_Z_HI       = 8'h12;
  localparam logic [7:0] REG_IRQ_FLAGS  = 8'h14;
  localparam logic [7:0] REG_RANGE      = 8'h20;
  localparam logic [7:0] REG_FIFO_CTRL  = 8'h2D;
  localparam logic [7:0] REG_FIFO_FLAGS = 8'h2F;
  localparam logic [7:0] REG_IRQ_OPT    = 8'h31;
  localparam logic [7:0] REG_PIN_CTRL   = 8'h33;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] RD_ZERO   = 8'h00;

  // Field positions
  localparam int FLG_ACQ_BIT    = 7;
  localparam int FLG_FIFO_BIT   = 5;
  localparam int MOTION_N       = 5;
  localparam int FIFO_EVT_N     = 3;
  localparam int OPT_PERSRC_BIT = 6;
  localparam int OPT_MERGE_BIT  = 5;
  localparam int OPT_PINSEL_BIT = 4;
  localparam int OPT_SWAP_BIT   = 3;
  localparam int PIN_A_IAH_BIT  = 2;
  localparam int PIN_A_IPP_BIT  = 3;
  localparam int PIN_B_IAH_BIT  = 6;
  localparam int PIN_B_IPP_BIT  = 7;
  localparam int MODE_RST_BIT   = 7;

  // Range codes
  localparam logic [2:0] RANGE_2G  = 3'h0;
  localparam logic [2:0] RANGE_4G  = 3'h1;
  localparam logic [2:0] RANGE_8G  = 3'h2;
  localparam logic [2:0] RANGE_12G = 3'h3;
  localparam logic [2:0] RANGE_16G = 3'h4;
  localparam logic [15:0] SAT_POS  = 16'h7FFF;
  localparam logic [15:0] SAT_NEG  = 16'h8000;
  localparam int          DIV12_MUL   = 5461;
  localparam int          DIV12_SHIFT = 15;
  localparam int          RAW_W       = 20;

  // Timing
  localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned ODR_MAX_SPS    = 2000;
  localparam int unsigned FAST_PERIOD_CYC = CLK_FREQ_HZ / ODR_MAX_SPS;
  localparam int unsigned WAKE_TIME_NS   = 10_000;
  localparam int unsigned WAKE_MAX_CYC   = WAKE_TIME_NS / CLK_PERIOD_NS;

  // Rate code to divisor of the fastest rate: 2000 down to 0.5 samples/s
  function automatic logic [15:0] psirq_rate_div(input logic [3:0] code);
    case (code)
      4'h0:    psirq_rate_div = 16'h0001;
      4'h1:    psirq_rate_div = 16'h0002;
      4'h2:    psirq_rate_div = 16'h0004;
      4'h3:    psirq_rate_div = 16'h0008;
      4'h4:    psirq_rate_div = 16'h0010;
      4'h5:    psirq_rate_div = 16'h0020;
      4'h6:    psirq_rate_div = 16'h0040;
      4'h7:    psirq_rate_div = 16'h0080;
      4'h8:    psirq_rate_div = 16'h0100;
      4'h9:    psirq_rate_div = 16'h01F4;
      4'hA:    psirq_rate_div = 16'h03E8;
      4'hB:    psirq_rate_div = 16'h07D0;
      default: psirq_rate_div = 16'h0FA0;
    endcase
  endfunction : psirq_rate_div

endpackage : psirq_pkg

`default_nettype wire

// ---- hw/psirq_pin_drv.sv ----
/*
  One interrupt pin driver: polarity and open-drain or push-pull drive.
  Assumes the request is a synchronous level; outputs are registered.
*/
`timescale 1ns/100ps
`default_nettype none

module psirq_pin_drv
  import psirq_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic req_in,
  input  wire logic active_high_in,
  input  wire logic push_pull_in,
  output logic      pin_out,
  output logic      pin_oe_out
);

  logic level_w;
  logic nxt_oe;

  // Level the pin should show while the request is up or down
  assign level_w = req_in ~^ active_high_in;
  // Open drain only pulls low; high is left to the pull-up
  assign nxt_oe  = push_pull_in | ~level_w;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pin_out    <= 1'b0;
      pin_oe_out <= 1'b0;
    end else begin
      pin_out    <= level_w & push_pull_in;
      pin_oe_out <= nxt_oe;
    end
  end

endmodule : psirq_pin_drv

`default_nettype wire

// ---- hw/psirq_top.sv ----
/*
  Power state control, sample formatting and interrupt routing of a
  three-axis motion sensor. Registers are reached through the host
  port's byte access strobes; serial bus framing sits outside.
*/
// Summary of operation
// - Three states only; state changes solely on a host mode write.
// - Power-up and reset leave the device in SLEEP.
// - Reset requests ignored in SLEEP; honoured in STANDBY and WAKE.
// - STANDBY to WAKE completes within one sample period, under 10 us.
// - SLEEP: internal timing halted, nothing sampled, registers fully accessible.
// - STANDBY: timing halted, sampling idle, registers fully accessible.
// - WAKE: continuous sampling; only mode register writable, all readable.
// - Sample rate programmable from 0.5 to 2000 samples per second.
// - Axis results signed 16-bit, saturating at 0x8000 and 0x7FFF.
// - Range field selects 2, 4, 8, 12 or 16 g full scale.
// - Mode codes: 00 SLEEP, 01 WAKE, 11 STANDBY.
// - SLEEP or STANDBY halts sensor and event sampling; WAKE starts it.
// - State readable in status register and held until host changes it.
// - Data registers update only after a bus STOP since the last update.
// - Both pins default open-drain active low; pin A sample, pin B FIFO.
// - Each pin's drive mode and polarity set independently at irq_pin_drive_control.
// - Sources: one sample, five motion, three FIFO events in two groups.
// - Write to irq_flags_and_clear clears pending interrupts; FIFO flags live at fifo_irq_flags.
// - Global clearing by default; irq_option_control bit 6 selects per-source clearing.
// - The two requests may be swapped between pins or merged.
// - When merged, irq_option_control bit 4 selects which pin carries the request.
// - Global mode: write data ignored, any write clears everything.
// - Per-source mode: ones clear matching flags, zeros leave them.
`timescale 1ns/100ps
`default_nettype none

module psirq_top
  import psirq_pkg::*;
#(
  parameter int unsigned FAST_PERIOD = FAST_PERIOD_CYC
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_n_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [7:0]              reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  input  wire logic                    bus_stop_in,
  input  wire logic signed [RAW_W-1:0] x_raw_in,
  input  wire logic signed [RAW_W-1:0] y_raw_in,
  input  wire logic signed [RAW_W-1:0] z_raw_in,
  input  wire logic [MOTION_N-1:0]     motion_evt_in,
  input  wire logic [FIFO_EVT_N-1:0]   fifo_evt_in,
  output logic [7:0]                   reg_rdata_out,
  output logic [1:0]                   state_out,
  output logic                         sampling_out,
  output logic                         irq_pin_a_out,
  output logic                         irq_pin_a_oe_out,
  output logic                         irq_pin_b_out,
  output logic                         irq_pin_b_oe_out
);

  localparam int A_WAKE_MAX = WAKE_MAX_CYC;
  // Scale a raw reading to the selected range and saturate to 16 bits
  function automatic logic [15:0] psirq_scale(input logic signed [RAW_W-1:0] raw,
                                              input logic [2:0] rng);
    logic signed [35:0] v;
    v = 36'(raw);
    if (rng == RANGE_4G) begin
      v = v >>> 1;
    end else if (rng == RANGE_8G) begin
      v = v >>> 2;
    end else if (rng == RANGE_12G) begin
      v = 36'((v * DIV12_MUL) >>> DIV12_SHIFT);
    end else if (rng == RANGE_16G) begin
      v = v >>> 3;
    end
    if (v[35:15] != {21{v[35]}}) begin
      psirq_scale = v[35] ? SAT_NEG : SAT_POS;
    end else begin
      psirq_scale = v[15:0];
    end
  endfunction : psirq_scale

  psirq_state_e   state_ff;
  logic [7:0]     irq_en_ff;
  logic [3:0]     rate_ff;
  logic [2:0]     range_ff;
  logic [7:0]     fifo_ctrl_ff;
  logic [7:0]     opt_ff;
  logic [7:0]     pin_ctrl_ff;
  logic [7:0]     flags_ff;
  logic [2:0]     fifo_flags_ff;
  logic [15:0]    x_res_ff;
  logic [15:0]    y_res_ff;
  logic [15:0]    z_res_ff;
  logic           stop_seen_ff;
  logic [31:0]    tick_cnt_ff;
  logic           route_a_ff;
  logic           route_b_ff;
  // Access decoding
  logic           wake_w;
  logic           mode_wr_w;
  logic           cfg_wr_w;
  logic           soft_rst_w;
  logic           clr_wr_w;
  logic           acq_rd_w;
  logic [31:0]    period_w;
  logic           tick_w;
  logic           upd_w;
  logic [7:0]     flag_set_w;
  logic [2:0]     fifo_set_w;
  logic [7:0]     clr_mask_w;
  logic           fifo_clr_w;
  logic           sm_req_w;
  logic           fifo_req_w;
  logic           merge_w;
  logic           nxt_route_a;
  logic           nxt_route_b;
  logic [7:0]     rd_mux_w;
  psirq_state_e   nxt_state;

  assign wake_w     = (state_ff == ST_WAKE);
  assign mode_wr_w  = reg_wr_in && (reg_addr_in == REG_MODE);
  assign cfg_wr_w   = reg_wr_in && !wake_w;
  assign soft_rst_w = mode_wr_w && reg_wdata_in[MODE_RST_BIT]
                      && (state_ff != ST_SLEEP);
  assign clr_wr_w   = cfg_wr_w && (reg_addr_in == REG_IRQ_FLAGS);
  assign acq_rd_w   = reg_rd_in && (reg_addr_in == REG_IRQ_FLAGS);
  // Sample timer runs only in WAKE
  assign period_w = 32'(FAST_PERIOD) * 32'(psirq_rate_div(rate_ff));
  assign tick_w   = wake_w && (tick_cnt_ff >= period_w - 32'h0000_0001);
  assign upd_w    = tick_w && stop_seen_ff;
  // Enabled events set flags; gated off outside WAKE
  assign flag_set_w = {tick_w & irq_en_ff[FLG_ACQ_BIT], 2'b00,
                       {MOTION_N{wake_w}} & motion_evt_in
                       & irq_en_ff[MOTION_N-1:0]};
  assign fifo_set_w = {FIFO_EVT_N{wake_w}} & fifo_evt_in
                      & fifo_ctrl_ff[FIFO_EVT_N-1:0];
  // Clear mask: global ignores data, per-source uses ones only
  assign clr_mask_w = !clr_wr_w ? 8'h00 :
                      (opt_ff[OPT_PERSRC_BIT] ? reg_wdata_in : 8'hFF);
  assign fifo_clr_w = clr_mask_w[FLG_FIFO_BIT];
  // Request groups and pin routing
  assign sm_req_w   = |(flags_ff & irq_en_ff & 8'hDF);
  assign fifo_req_w = |(fifo_flags_ff & fifo_ctrl_ff[FIFO_EVT_N-1:0]);
  assign merge_w    = opt_ff[OPT_MERGE_BIT];
  always_comb begin
    if (merge_w) begin
      nxt_route_a = !opt_ff[OPT_PINSEL_BIT] && (sm_req_w || fifo_req_w);
      nxt_route_b = opt_ff[OPT_PINSEL_BIT] && (sm_req_w || fifo_req_w);
    end else if (opt_ff[OPT_SWAP_BIT]) begin
      nxt_route_a = fifo_req_w;
      nxt_route_b = sm_req_w;
    end else begin
      nxt_route_a = sm_req_w;
      nxt_route_b = fifo_req_w;
    end
  end

  // Mode decode: an unused code keeps the current state
  always_comb begin
    nxt_state = state_ff;
    if (mode_wr_w) begin
      if (reg_wdata_in[1:0] == MODE_CODE_SLEEP) begin
        nxt_state = ST_SLEEP;
      end else if (reg_wdata_in[1:0] == MODE_CODE_WAKE) begin
        nxt_state = ST_WAKE;
      end else if (reg_wdata_in[1:0] == MODE_CODE_STANDBY) begin
        nxt_state = ST_STANDBY;
      end
    end
  end

  // Read multiplexer
  always_comb begin
    if (reg_addr_in == REG_STATUS || reg_addr_in == REG_MODE) begin
      rd_mux_w = {6'h00, state_ff};
    end else if (reg_addr_in == REG_IRQ_EN) begin
      rd_mux_w = irq_en_ff;
    end else if (reg_addr_in == REG_RATE) begin
      rd_mux_w = {4'h0, rate_ff};
    end else if (reg_addr_in == REG_X_LO) begin
      rd_mux_w = x_res_ff[7:0];
    end else if (reg_addr_in == REG_X_HI) begin
      rd_mux_w = x_res_ff[15:8];
    end else if (reg_addr_in == REG_Y_LO) begin
      rd_mux_w = y_res_ff[7:0];
    end else if (reg_addr_in == REG_Y_HI) begin
      rd_mux_w = y_res_ff[15:8];
    end else if (reg_addr_in == REG_Z_LO) begin
      rd_mux_w = z_res_ff[7:0];
    end else if (reg_addr_in == REG_Z_HI) begin
      rd_mux_w = z_res_ff[15:8];
    end else if (reg_addr_in == REG_IRQ_FLAGS) begin
      rd_mux_w = flags_ff | {2'b00, |fifo_flags_ff, 5'h00};
    end else if (reg_addr_in == REG_RANGE) begin
      rd_mux_w = {5'h00, range_ff};
    end else if (reg_addr_in == REG_FIFO_CTRL) begin
      rd_mux_w = fifo_ctrl_ff;
    end else if (reg_addr_in == REG_FIFO_FLAGS) begin
      rd_mux_w = {5'h00, fifo_flags_ff};
    end else if (reg_addr_in == REG_IRQ_OPT) begin
      rd_mux_w = opt_ff;
    end else if (reg_addr_in == REG_PIN_CTRL) begin
      rd_mux_w = pin_ctrl_ff;
    end else begin
      rd_mux_w = RD_ZERO;
    end
  end

  // State and configuration; soft reset returns all to power-up values
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || soft_rst_w) begin
      state_ff     <= ST_SLEEP;
      irq_en_ff    <= CFG_RESET;
      rate_ff      <= CFG_RESET[3:0];
      range_ff     <= CFG_RESET[2:0];
      fifo_ctrl_ff <= CFG_RESET;
      opt_ff       <= CFG_RESET;
      pin_ctrl_ff  <= CFG_RESET;
    end else begin
      state_ff <= nxt_state;
      if (cfg_wr_w && reg_addr_in == REG_IRQ_EN)    irq_en_ff    <= reg_wdata_in;
      if (cfg_wr_w && reg_addr_in == REG_RATE)      rate_ff      <= reg_wdata_in[3:0];
      if (cfg_wr_w && reg_addr_in == REG_RANGE)     range_ff     <= reg_wdata_in[2:0];
      if (cfg_wr_w && reg_addr_in == REG_FIFO_CTRL) fifo_ctrl_ff <= reg_wdata_in;
      if (cfg_wr_w && reg_addr_in == REG_IRQ_OPT)   opt_ff       <= reg_wdata_in;
      if (cfg_wr_w && reg_addr_in == REG_PIN_CTRL)  pin_ctrl_ff  <= reg_wdata_in;
    end
  end

  // Flags: a set in the clearing cycle wins; reading fifo_irq_flags changes nothing
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || soft_rst_w) begin
      flags_ff      <= CFG_RESET;
      fifo_flags_ff <= CFG_RESET[2:0];
    end else begin
      flags_ff <= (flags_ff & ~clr_mask_w & ~{acq_rd_w, 7'h00} & 8'hDF)
                  | flag_set_w;
      fifo_flags_ff <= (fifo_flags_ff & ~{FIFO_EVT_N{fifo_clr_w}})
                       | fifo_set_w;
    end
  end

  // Sample timer, stop tracking and result registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || soft_rst_w) begin
      tick_cnt_ff  <= 32'h0000_0000;
      stop_seen_ff <= 1'b0;
      x_res_ff     <= 16'h0000;
      y_res_ff     <= 16'h0000;
      z_res_ff     <= 16'h0000;
    end else begin
      tick_cnt_ff  <= (tick_w || !wake_w) ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
      stop_seen_ff <= bus_stop_in || (stop_seen_ff && !upd_w);
      if (upd_w) begin
        x_res_ff <= psirq_scale(x_raw_in, range_ff);
        y_res_ff <= psirq_scale(y_raw_in, range_ff);
        z_res_ff <= psirq_scale(z_raw_in, range_ff);
      end
    end
  end
  // Port registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= RD_ZERO;
      state_out     <= MODE_CODE_SLEEP;
      sampling_out  <= 1'b0;
      route_a_ff    <= 1'b0;
      route_b_ff    <= 1'b0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux_w : RD_ZERO;
      state_out     <= soft_rst_w ? MODE_CODE_SLEEP : nxt_state;
      sampling_out  <= !soft_rst_w && (nxt_state == ST_WAKE);
      route_a_ff    <= nxt_route_a;
      route_b_ff    <= nxt_route_b;
    end
  end

  psirq_pin_drv u_pin_a (
    .clk_in         (clk_in),
    .reset_n_in     (reset_n_in),
    .req_in         (route_a_ff),
    .active_high_in (pin_ctrl_ff[PIN_A_IAH_BIT]),
    .push_pull_in   (pin_ctrl_ff[PIN_A_IPP_BIT]),
    .pin_out        (irq_pin_a_out),
    .pin_oe_out     (irq_pin_a_oe_out)
  );
  psirq_pin_drv u_pin_b (
    .clk_in         (clk_in),
    .reset_n_in     (reset_n_in),
    .req_in         (route_b_ff),
    .active_high_in (pin_ctrl_ff[PIN_B_IAH_BIT]),
    .push_pull_in   (pin_ctrl_ff[PIN_B_IPP_BIT]),
    .pin_out        (irq_pin_b_out),
    .pin_oe_out     (irq_pin_b_oe_out)
  );
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_reset_sleep: assert property (
    !$past(reset_n_in) |-> state_ff == ST_SLEEP) else $error("not in SLEEP after reset");
  a_state_hold: assert property (
    !mode_wr_w |=> $stable(state_ff)) else $error("state changed without mode write");
  a_mode_wake: assert property (
    mode_wr_w && !soft_rst_w && reg_wdata_in[1:0] == MODE_CODE_WAKE
    |=> state_ff == ST_WAKE && state_out == MODE_CODE_WAKE) else $error("WAKE code not taken");
  a_wake_time: assert property (
    state_ff == ST_STANDBY && mode_wr_w && reg_wdata_in[1:0] == MODE_CODE_WAKE
    && !soft_rst_w |-> ##[1:A_WAKE_MAX] state_ff == ST_WAKE) else $error("wake too slow");
  a_idle_no_tick: assert property (
    !wake_w |-> !tick_w && flag_set_w == 8'h00 && fifo_set_w == 3'h0)
    else $error("sampling outside WAKE");
  a_wake_wr_block: assert property (
    wake_w && reg_wr_in && reg_addr_in == REG_PIN_CTRL |=> $stable(pin_ctrl_ff))
    else $error("write in WAKE took effect");
  a_sleep_no_rst: assert property (
    state_ff == ST_SLEEP && mode_wr_w && reg_wdata_in[1:0] == MODE_CODE_STANDBY
    |=> state_ff == ST_STANDBY && $stable(opt_ff)) else $error("reset honoured in SLEEP");
  a_global_clear: assert property (
    clr_wr_w && !opt_ff[OPT_PERSRC_BIT] && flag_set_w == 8'h00 && fifo_set_w == 3'h0
    |=> flags_ff == 8'h00 && fifo_flags_ff == 3'h0) else $error("global clear missed");
  a_persrc_keep: assert property (
    clr_wr_w && opt_ff[OPT_PERSRC_BIT] && !reg_wdata_in[1] && flags_ff[1]
    |=> flags_ff[1]) else $error("zero bit cleared a flag");
  a_fifo_rd_keep: assert property (
    !fifo_clr_w && !soft_rst_w |=> ($past(fifo_flags_ff) & ~fifo_flags_ff) == 3'h0)
    else $error("FIFO flag lost without clear");
  a_data_stop: assert property (
    !stop_seen_ff && !soft_rst_w |=> $stable(x_res_ff) && $stable(y_res_ff) && $stable(z_res_ff))
    else $error("data updated without STOP");
  a_pin_a_drive: assert property (
    route_a_ff && pin_ctrl_ff == CFG_RESET ##1 $stable(pin_ctrl_ff)
    |-> irq_pin_a_oe_out && !irq_pin_a_out) else $error("pin A not asserted low");

  c_wake: cover property (state_ff == ST_STANDBY ##1 state_ff == ST_WAKE);
  c_sample: cover property (upd_w);
  c_merge_b: cover property (merge_w && opt_ff[OPT_PINSEL_BIT] && route_b_ff);
  c_swap: cover property (opt_ff[OPT_SWAP_BIT] && !merge_w && route_a_ff);

endmodule : psirq_top

`default_nettype wire

// ---- verif/psirq_host_model.sv ----
/*
  Host processor model on the register port: byte accesses and STOP.
  Assumes a free-running clk_in; drives only at falling edges.
*/
`timescale 1ns/100ps
`default_nettype none

module psirq_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic            stop_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    stop_out = 1'b0;
  end

  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= we;
    rd_out <= !we;
    @(negedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    // Released bus shows no stale value
    addr_out <= ~a;
    wdata_out <= ~d;
    q = rdata_in;
  endtask : xfer

  // One STOP between samples
  task automatic stop;
    @(negedge clk_in);
    stop_out <= 1'b1;
    @(negedge clk_in);
    stop_out <= 1'b0;
  endtask : stop
endmodule : psirq_host_model

`default_nettype wire

// ---- verif/tb_power_state_and_irq_routing.sv ----
/*
  Self-checking bench: state control, sampling and pin routing.
  Assumes FAST_PERIOD of 20; released open-drain pins pulled high.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module tb_power_state_and_irq_routing
  import psirq_pkg::*;
;
  logic                    clk_in, reset_n_in, wr, rd, stp, sm, pa, pa_oe, pb, pb_oe;
  logic [7:0]              addr, wd, rdata, q;
  logic [1:0]              st;
  logic signed [RAW_W-1:0] x_raw;
  logic [4:0]              mot;
  logic [2:0]              ff;
  int                      err_count, comparisons;
  wire lvl_a = pa_oe ? pa : 1'b1;
  wire lvl_b = pb_oe ? pb : 1'b1;

  psirq_top #(.FAST_PERIOD(20)) u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .bus_stop_in(stp), .x_raw_in(x_raw), .y_raw_in(20'sh0_0000),
    .z_raw_in(20'sh0_0000), .motion_evt_in(mot), .fifo_evt_in(ff),
    .reg_rdata_out(rdata), .state_out(st), .sampling_out(sm), .irq_pin_a_out(pa),
    .irq_pin_a_oe_out(pa_oe), .irq_pin_b_out(pb), .irq_pin_b_oe_out(pb_oe));
  psirq_host_model u_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wd), .wr_out(wr), .rd_out(rd), .stop_out(stp));

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask : w
  task automatic r(input logic [7:0] a);
    u_host.xfer(1'b0, a, 8'h00, q);
  endtask : r
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  task automatic evt(input logic [4:0] m, input logic [2:0] f);
    mot = m;
    ff = f;
    cyc(1);
    mot = 5'h00;
    ff = 3'h0;
    cyc(5);
  endtask : evt
  task automatic summarize;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    cyc(20000);
    err_count++;
    summarize();
  end

  initial begin
    reset_n_in = 1'b0;
    x_raw = 20'sh0_0000;
    mot = 5'h00;
    ff = 3'h0;
    cyc(2);
    reset_n_in = 1'b1;
    `CHK("state", 2'b00, st)
    `CHK("pin_a_oe", 1'b0, pa_oe)
    w(REG_PIN_CTRL, 8'h08);
    w(REG_MODE, 8'h80);
    r(REG_PIN_CTRL);
    `CHK("sleep_reset", 8'h08, q)
    w(REG_IRQ_EN, 8'h03);
    w(REG_FIFO_CTRL, 8'h01);
    w(REG_MODE, {6'h00, MODE_CODE_STANDBY});
    `CHK("standby", 2'b11, st)
    r(REG_STATUS);
    `CHK("status", 2'b11, q[1:0])
    evt(5'h01, 3'h0);
    r(REG_IRQ_FLAGS);
    `CHK("idle_flags", 8'h00, q)
    w(REG_MODE, {6'h00, MODE_CODE_WAKE});
    `CHK("sampling", 1'b1, sm)
    w(REG_IRQ_EN, 8'h00);
    r(REG_IRQ_EN);
    `CHK("wake_wr", 8'h03, q)
    evt(5'h03, 3'h1);
    `CHK("pin_a", 1'b0, lvl_a)
    `CHK("pin_b", 1'b0, lvl_b)
    w(REG_MODE, {6'h00, MODE_CODE_STANDBY});
    w(REG_IRQ_OPT, 8'h40);
    w(REG_IRQ_FLAGS, 8'h01);
    r(REG_IRQ_FLAGS);
    `CHK("per_src", 8'h22, q & 8'h7F)
    repeat (2) begin
      r(REG_FIFO_FLAGS);
      `CHK("fifo_flags", 8'h01, q)
    end
    w(REG_IRQ_FLAGS, 8'h20);
    cyc(5);
    `CHK("fifo_clr", 1'b1, lvl_b)
    w(REG_IRQ_OPT, 8'h48);
    cyc(5);
    `CHK("swap_b", 1'b0, lvl_b)
    `CHK("swap_a", 1'b1, lvl_a)
    w(REG_IRQ_OPT, 8'h70);
    cyc(5);
    `CHK("merge_b", 1'b0, lvl_b)
    w(REG_IRQ_OPT, 8'h60);
    cyc(5);
    `CHK("merge_a", 2'b01, {lvl_a, lvl_b})
    w(REG_PIN_CTRL, 8'h0C);
    cyc(5);
    `CHK("act_high", 1'b1, lvl_a)
    w(REG_IRQ_OPT, 8'h00);
    w(REG_IRQ_FLAGS, 8'h00);
    cyc(5);
    r(REG_IRQ_FLAGS);
    `CHK("global_clr", 8'h00, q & 8'h7F)
    `CHK("pin_idle", 1'b0, lvl_a)
    x_raw = 20'sh4_0000;
    u_host.stop();
    w(REG_MODE, {6'h00, MODE_CODE_WAKE});
    cyc(60);
    r(REG_X_HI);
    `CHK("sat_pos", 8'h7F, q)
    x_raw = 20'sh8_0000;
    cyc(60);
    r(REG_X_HI);
    `CHK("no_stop", 8'h7F, q)
    u_host.stop();
    cyc(60);
    r(REG_X_HI);
    `CHK("sat_neg", 8'h80, q)
    w(REG_MODE, {6'h00, MODE_CODE_STANDBY});
    w(REG_RANGE, {5'h00, RANGE_16G});
    x_raw = 20'sh0_0800;
    u_host.stop();
    w(REG_MODE, {6'h00, MODE_CODE_WAKE});
    cyc(60);
    r(REG_X_HI);
    `CHK("range_16g", 8'h01, q)
    w(REG_MODE, 8'h81);
    `CHK("soft_rst", 2'b00, st)
    r(REG_PIN_CTRL);
    `CHK("rst_cfg", 8'h00, q)
    summarize();
  end
endmodule : tb_power_state_and_irq_routing

`default_nettype wire
